// >>> mrr_cfg.svh
// mrr_cfg.svh: offsets, field positions and reset values of the measurement result registers
// assumes: included by mrr_pkg.sv and the design modules by bare name
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MRR_OFS_CURR_HI 8'h10
`define MRR_OFS_CURR_LO 8'h11
`define MRR_OFS_VOLT_HI 8'h12
// ----------------------------------------
// field layout of the high and low bytes
// ----------------------------------------
`define MRR_MSB_HI  11
`define MRR_MSB_LO  8
`define MRR_LSB_HI  7
`define MRR_BIT_INT 5
`define MRR_BIT_WRN 6
// ----------------------------------------
// reset values and scaling
// ----------------------------------------
`define MRR_RST_BYTE  8'h00
`define MRR_RST_MEAS  12'h000
`define MRR_LSB_UV    1220
`define MRR_GAIN_MUL  2
`define MRR_GAIN_ADD  2
`endif

// >>> mrr_pkg.sv
// mrr_pkg.sv: types shared by the measurement result register bank
// assumes: mrr_cfg.svh on the include path
`include "mrr_cfg.svh"
`default_nettype none
package mrr_pkg;
  typedef logic signed [11:0] mrr_meas_t;
  typedef logic [7:0]         mrr_byte_t;
  typedef logic [7:0]         mrr_addr_t;
  typedef enum logic [1:0] {MRR_SEL_NONE, MRR_SEL_CURR_HI, MRR_SEL_CURR_LO, MRR_SEL_VOLT_HI} mrr_sel_t;
endpackage
`default_nettype wire

// >>> mrr_if.sv
// mrr_if.sv: carrier between the register bank and its byte formatter
// assumes: one clock domain, driven by mrr_top
`timescale 1ns/10ps
`default_nettype none
interface mrr_if;
  mrr_pkg::mrr_meas_t meas;
  logic               irq_act;
  logic               warn;
  mrr_pkg::mrr_byte_t hi_byte;
  modport src (output meas, output irq_act, output warn, input hi_byte);
  modport fmt (input meas, input irq_act, input warn, output hi_byte);
endinterface
`default_nettype wire

// >>> mrr_hi_fmt.sv
// mrr_hi_fmt.sv: builds one high-byte register image from a result and status bits
// assumes: purely combinational, used once per high-byte register
`timescale 1ns/10ps
`include "mrr_cfg.svh"
`default_nettype none
module mrr_hi_fmt (
  mrr_if.fmt bus
);
  // unused bits 4 and 7 stay zero
  assign bus.hi_byte = {1'b0, bus.warn, bus.irq_act, 1'b0,
                        bus.meas[`MRR_MSB_HI:`MRR_MSB_LO]};
endmodule // mrr_hi_fmt
`default_nettype wire

// >>> mrr_top.sv
// mrr_top.sv: read-only current and voltage result registers
// assumes: conversion results and condition flags come from the converter blocks,
// and the serial register port presents an address with a read strobe
`timescale 1ns/10ps
`include "mrr_cfg.svh"
`default_nettype none
module mrr_top (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               conv_done,
  input  wire logic               conv_is_volt,
  input  wire mrr_pkg::mrr_meas_t conv_result,
  input  wire logic [4:0]         curr_gain_set,
  input  wire logic [1:0]         volt_gain_set,
  input  wire logic               interrupt_pin_n,
  input  wire logic               over_temp,
  input  wire logic               under_voltage,
  input  wire logic               over_current,
  input  wire logic               over_voltage,
  input  wire mrr_pkg::mrr_addr_t reg_addr,
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  output var  mrr_pkg::mrr_byte_t reg_rdata,
  output var  logic               reg_hit,
  output var  logic [6:0]         curr_gain,
  output var  logic [3:0]         volt_gain
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n_int = rst_s2_r;

  // ----------------------------------------
  // result capture
  // ----------------------------------------
  mrr_pkg::mrr_meas_t curr_r;
  mrr_pkg::mrr_meas_t volt_r;
  logic               irq_act_r;
  logic               curr_warn_r;
  logic               volt_warn_r;
  // the converter already codes two's complement; kept signed end to end
  wire mrr_pkg::mrr_meas_t curr_nxt = (conv_done && !conv_is_volt) ? conv_result : curr_r;
  wire mrr_pkg::mrr_meas_t volt_nxt = (conv_done && conv_is_volt) ? conv_result : volt_r;
  wire curr_warn_nxt = over_temp | under_voltage | over_current;
  wire volt_warn_nxt = over_temp | under_voltage | over_voltage;
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      curr_r      <= `MRR_RST_MEAS;
      volt_r      <= `MRR_RST_MEAS;
      irq_act_r   <= 1'b0;
      curr_warn_r <= 1'b0;
      volt_warn_r <= 1'b0;
    end else begin
      curr_r      <= curr_nxt;
      volt_r      <= volt_nxt;
      irq_act_r   <= ~interrupt_pin_n;
      curr_warn_r <= curr_warn_nxt;
      volt_warn_r <= volt_warn_nxt;
    end
  end

  // ----------------------------------------
  // channel gain for host-side scaling
  // ----------------------------------------
  // one code step is 1.22 mV at the input divided by shunt times gain; the gain is exported
  // so scaling stays outside the bank, saving a divider here
  // widths hold the largest setting: 2*31+2 = 64 and 2*3+2 = 8
  wire [6:0] curr_gain_nxt = 7'(`MRR_GAIN_MUL * curr_gain_set + `MRR_GAIN_ADD);
  wire [3:0] volt_gain_nxt = 4'(`MRR_GAIN_MUL * volt_gain_set + `MRR_GAIN_ADD);
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      curr_gain <= 7'(`MRR_GAIN_ADD);
      volt_gain <= 4'(`MRR_GAIN_ADD);
    end else begin
      curr_gain <= curr_gain_nxt;
      volt_gain <= volt_gain_nxt;
    end
  end

  // ----------------------------------------
  // high-byte images
  // ----------------------------------------
  mrr_if curr_hi_if ();
  mrr_if volt_hi_if ();
  assign curr_hi_if.meas    = curr_r;
  assign curr_hi_if.irq_act = irq_act_r;
  assign curr_hi_if.warn    = curr_warn_r;
  assign volt_hi_if.meas    = volt_r;
  assign volt_hi_if.irq_act = irq_act_r;
  assign volt_hi_if.warn    = volt_warn_r;
  mrr_hi_fmt u_curr_hi (.bus(curr_hi_if));
  mrr_hi_fmt u_volt_hi (.bus(volt_hi_if));

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  wire hit_curr_hi = (reg_addr == `MRR_OFS_CURR_HI);
  wire hit_curr_lo = (reg_addr == `MRR_OFS_CURR_LO);
  wire hit_volt_hi = (reg_addr == `MRR_OFS_VOLT_HI);
  wire any_hit     = hit_curr_hi | hit_curr_lo | hit_volt_hi;
  wire mrr_pkg::mrr_byte_t rd_mux =
    hit_curr_hi ? curr_hi_if.hi_byte :
    hit_curr_lo ? mrr_pkg::mrr_byte_t'(curr_r[`MRR_LSB_HI:0]) :
    hit_volt_hi ? volt_hi_if.hi_byte : `MRR_RST_BYTE;
  // reg_wr only blocks the read strobe and never reaches the data path: these registers are read only
  wire rd_take = reg_rd & ~reg_wr;
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      reg_rdata <= `MRR_RST_BYTE;
      reg_hit   <= 1'b0;
    end else if (rd_take) begin
      reg_rdata <= rd_mux;
      reg_hit   <= any_hit;
    end
  end
endmodule // mrr_top
`default_nettype wire

// >>> mrr_properties.sv
// mrr_properties.sv: port checker for the result register bank
// assumes: bound to mrr_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module mrr_properties (
  input wire logic               clk_sys, rst_b, conv_done, conv_is_volt, reg_rd, reg_wr, reg_hit,
  input wire logic               interrupt_pin_n, over_temp, under_voltage, over_current, over_voltage,
  input wire mrr_pkg::mrr_meas_t conv_result,
  input wire logic [4:0]         curr_gain_set,
  input wire logic [1:0]         volt_gain_set,
  input wire mrr_pkg::mrr_addr_t reg_addr,
  input wire mrr_pkg::mrr_byte_t reg_rdata,
  input wire logic [6:0]         curr_gain,
  input wire logic [3:0]         volt_gain
);
  // ----------------------------------------
  // shadow copies; rq skips the synchroniser window after reset
  // ----------------------------------------
  logic [11:0] cur_q, vol_q;
  logic [3:0]  rq;
  wire logic   rd_ok = reg_rd & ~reg_wr & rq[3];
  wire logic   h10   = rd_ok && reg_addr == 8'h10;
  wire logic   h11   = rd_ok && reg_addr == 8'h11;
  wire logic   h12   = rd_ok && reg_addr == 8'h12;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) {rq, cur_q, vol_q} <= '0;
    else begin
      rq <= {rq[2:0], 1'b1};
      if (conv_done && !conv_is_volt) cur_q <= conv_result;
      if (conv_done && conv_is_volt) vol_q <= conv_result;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_curr_high: assert property (h10 |=> reg_rdata[3:0] == $past(cur_q[11:8])) else $error("curr high");
  chk_curr_low: assert property (h11 |=> reg_rdata == $past(cur_q[7:0])) else $error("curr low");
  chk_volt_high: assert property (h12 |=> reg_rdata[3:0] == $past(vol_q[11:8])) else $error("volt high");
  chk_irq_bit: assert property (h10 || h12 |=> reg_rdata[5] == !$past(interrupt_pin_n, 2)) else $error("irq");
  chk_curr_warn: assert property (h10 |=> reg_rdata[6] == $past(over_temp | under_voltage | over_current, 2))
    else $error("curr warn");
  chk_volt_warn: assert property (h12 |=> reg_rdata[6] == $past(over_temp | under_voltage | over_voltage, 2))
    else $error("volt warn");
  chk_spare_zero: assert property (h10 || h12 |=> !reg_rdata[7] && !reg_rdata[4]) else $error("spare");
  chk_write_ign: assert property (reg_wr |=> $stable(reg_rdata) && $stable(reg_hit)) else $error("write");
  chk_gain_calc: assert property (rq[3] |-> curr_gain == 7'(2 * $past(curr_gain_set) + 2)
    && volt_gain == 4'(2 * $past(volt_gain_set) + 2)) else $error("gain");
endmodule // mrr_properties
bind mrr_top mrr_properties i_chk (.*);
`default_nettype wire

// >>> mrr_host.sv
// mrr_host.sv: host side of the register port
// assumes: the bench calls acc; signals move at the falling edge
`timescale 1ns/10ps
`default_nettype none
module mrr_host (
  input  wire logic               clk_sys,
  output var  mrr_pkg::mrr_addr_t reg_addr,
  output var  logic               reg_rd,
  output var  logic               reg_wr
);
  initial {reg_addr, reg_rd, reg_wr} = '0;
  // w=1 is a write; the read strobe stays up so the block must refuse it
  task automatic acc(input logic w, input mrr_pkg::mrr_addr_t a);
    @(negedge clk_sys);
    {reg_addr, reg_rd, reg_wr} = {a, 1'b1, w};
    @(negedge clk_sys);
    {reg_addr, reg_rd, reg_wr} = {~a, 2'b00}; // released bus shows no stale address
  endtask
endmodule // mrr_host
`default_nettype wire

// >>> mrr_top_tb.sv
// mrr_top_tb.sv: self-checking bench for mrr_top
// assumes: mrr_properties binds itself to mrr_top
`timescale 1ns/10ps
`default_nettype none
module mrr_top_tb;
  logic               clk_sys = 0, rst_b = 0, conv_done = 0, conv_is_volt = 0, interrupt_pin_n = 1, reg_hit;
  logic               over_temp = 0, under_voltage = 0, over_current = 0, over_voltage = 0, reg_rd, reg_wr;
  mrr_pkg::mrr_meas_t conv_result = '0, c_exp, v_exp, corner [3] = '{12'h800, 12'h7FF, 12'hFFF};
  logic [4:0]         curr_gain_set = '0;
  logic [1:0]         volt_gain_set = '0;
  mrr_pkg::mrr_addr_t reg_addr;
  mrr_pkg::mrr_byte_t reg_rdata;
  logic [6:0]         curr_gain;
  logic [3:0]         volt_gain;
  int                 err_total = 0, comparisons = 0;
  wire logic          wc = over_temp | under_voltage | over_current;
  wire logic          wv = over_temp | under_voltage | over_voltage;
  mrr_top i_dut (.*);
  mrr_host i_host (.*);
  function automatic mrr_pkg::mrr_byte_t hi_exp(mrr_pkg::mrr_meas_t m, logic w);
    return {1'b0, w, ~interrupt_pin_n, 1'b0, m[11:8]};
  endfunction
  task automatic cmp(mrr_pkg::mrr_byte_t got, mrr_pkg::mrr_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(mrr_pkg::mrr_addr_t a, mrr_pkg::mrr_byte_t e, logic w = 0);
    i_host.acc(w, a);
    cmp(reg_rdata, e);
    if (!w) cmp(8'(reg_hit), 8'(a >= 8'h10 && a <= 8'h12));
  endtask
  task automatic conv(logic v, mrr_pkg::mrr_meas_t r);
    @(negedge clk_sys);
    {conv_done, conv_is_volt, conv_result} = {1'b1, v, r};
    @(negedge clk_sys);
    conv_done = 0;
  endtask
  task automatic end_sim;
    $display("err_total %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #20 clk_sys = ~clk_sys;
  // about 600 cycles needed; generous margin
  initial begin
    #(40 * 3000);
    err_total++;
    end_sim;
  end
  initial begin
    void'($urandom(23435));
    repeat (10) @(negedge clk_sys);
    rst_b = 1;
    repeat (4) @(negedge clk_sys);
    for (int a = 8'h10; a < 8'h13; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 40; i++) begin
      c_exp = i < 3 ? corner[i] : 12'($urandom);
      v_exp = i < 3 ? corner[2 - i] : 12'($urandom);
      {interrupt_pin_n, over_temp, under_voltage, over_current, over_voltage} = 5'($urandom);
      curr_gain_set = i < 3 ? 5'h1F : 5'($urandom_range(31));
      volt_gain_set = i < 3 ? 2'h3 : 2'($urandom_range(3));
      conv(0, c_exp);
      conv(1, v_exp);
      rd(8'h10, hi_exp(c_exp, wc));
      rd(8'h11, c_exp[7:0]);
      rd(8'h12, hi_exp(v_exp, wv));
      rd(8'h11, hi_exp(v_exp, wv), 1);
      rd(8'($urandom_range(255, 19)), 8'h00);
      cmp(8'(curr_gain), 8'(2 * curr_gain_set + 2));
      cmp(8'(volt_gain), 8'(2 * volt_gain_set + 2));
    end
    end_sim;
  end
endmodule // mrr_top_tb
`default_nettype wire
